// ==== hw/barrier_sync_node.sv ====
// barrier_sync_node: barrier register unit with APB registers, four-phase
// fan-in transfers, two fan units and the system combine unit.
// Assumes peers run in lock step with the same phase count and sync delay.
//
// Behaviour
// - processor arrival sets the selected bit of the low or high register.
// - a set bit holds until its channel completion input reads 1.
// - completion clears the bit and raises the interrupt when enabled.
// - bits go to fan units as four 4-bit transfers.
// - each fan-in stage ANDs four bits into one.
// - the fan-in is a five-level AND tree.
// - fan-out replicates each result to four, over five levels.
// - shortcut select 1 routes AND output into the paired fan-out.
// - route select 0 makes the even unit forward n+0 and n+1.
// - route select 1 makes the odd unit forward n+2 and n+3.
// - a level-one bypass point serves four processors, two per node.
// - combine unit ANDs all module bits and broadcasts the result.
// - I/O and redundant first, then processors, then other chassis.
// - two chassis exchange chassis ANDs and both AND them.
// - four chassis: edges feed centers, centers exchange and return.
// - fan-out retraces fan-in nodes, replicating instead of ANDing.
// - mode bit 0 closes the level-one point, 1 passes upward.
`timescale 1ns/1ps
`default_nettype none
module barrier_sync_node
    import barrier_sync_pkg::*;
(
    // clock, reset, enable
    input  wire logic                                   i_clk,
    input  wire logic                                   i_rst,
    input  wire logic                                   i_ce,
    // apb slave
    input  wire logic                                   i_psel,
    input  wire logic                                   i_penable,
    input  wire logic                                   i_pwrite,
    input  wire logic [11:0]                            i_paddr,
    input  wire logic [31:0]                            i_pwdata,
    output logic      [31:0]                            o_prdata,
    output logic                                        o_pready,
    output logic                                        o_pslverr,
    // fan network pins, channels n+0..n+3
    input  wire logic [LEVELS-1:0][NIBBLE-1:0][PEERS-1:0] i_peer_fanin,
    input  wire logic [NIBBLE-1:0]                      i_top_result,
    output logic      [NIBBLE-1:0]                      o_tree_up,
    output logic      [LEVELS-1:0][NIBBLE-1:0][PEERS-1:0] o_peer_fanout,
    output logic      [NIBBLE-1:0]                      o_fanin_nibble,
    output logic      [1:0]                             o_fanin_phase,
    // system combine pins
    input  wire logic [NIBBLE-1:0]                      i_sys_pe,
    input  wire logic [NIBBLE-1:0]                      i_sys_io,
    input  wire logic [NIBBLE-1:0]                      i_sys_red,
    input  wire logic [NIBBLE-1:0]                      i_sys_peer,
    input  wire logic [NIBBLE-1:0]                      i_sys_edge,
    output logic      [NIBBLE-1:0]                      o_sys_peer,
    output logic      [NIBBLE-1:0]                      o_sys_edge,
    output logic      [NIBBLE-1:0]                      o_sys_broadcast,
    // barrier interrupt level
    output logic                                        o_barrier_irq
);
    typedef struct packed {
        logic [NUM_BITS-1:0]                          bits;
        logic [LEVELS-1:0]                            mode;
        logic                                         irq_en;
        logic [1:0]                                   chassis;
        logic                                         irq;
        logic [1:0]                                   phase;
        logic [NIBBLE-1:0]                            nib;
        logic [1:0]                                   nib_phase;
        logic [SYNC_DEPTH-1:0][NIBBLE-1:0]            nib_d;
        logic [SYNC_DEPTH:0][1:0]                     ph_d;
        logic [LEVELS-1:0][NIBBLE-1:0][PEERS-1:0]     peer_s1;
        logic [LEVELS-1:0][NIBBLE-1:0][PEERS-1:0]     peer_s2;
        logic [NIBBLE-1:0]                            top_s1;
        logic [NIBBLE-1:0]                            top_s2;
        logic [31:0]                                  rdata;
    } node_state_t;

    node_state_t         cur;
    node_state_t         next_cur;
    logic [NIBBLE-1:0]   done;
    logic [NUM_BITS-1:0] set_mask;
    logic [NUM_BITS-1:0] clr_mask;
    logic                wr_acc;
    logic                hit;
    logic [LEVELS-1:0]   shortcut;

    // zero-wait slave; errors flagged combinationally in the access phase
    assign wr_acc    = i_psel & i_penable & i_pwrite;
    assign hit       = (i_paddr == ADDR_LOW) || (i_paddr == ADDR_HIGH) ||
                       (i_paddr == ADDR_MODE) || (i_paddr == ADDR_CTRL) ||
                       (i_paddr == ADDR_STATUS);
    assign o_pready  = 1'b1;
    assign o_pslverr = i_psel & i_penable & ~hit;
    // mode bit 0 means close here
    assign shortcut  = ~cur.mode;

    // arrival and completion masks
    always_comb begin
        set_mask = '0;
        clr_mask = '0;
        if (wr_acc && i_paddr == ADDR_LOW) begin
            set_mask[REG_BITS-1:0] = i_pwdata[REG_BITS-1:0];
        end
        if (wr_acc && i_paddr == ADDR_HIGH) begin
            set_mask[NUM_BITS-1:REG_BITS] = i_pwdata[REG_BITS-1:0];
        end
        for (int c = 0; c < NIBBLE; c++) begin
            if (done[c]) begin
                clr_mask[{cur.ph_d[SYNC_DEPTH], 2'(c)}] = 1'b1;
            end
        end
    end

    // register file, transfer sequencer and pin synchronisers
    always_comb begin
        next_cur = cur;
        // arrival sets, and wins over a same-cycle completion
        next_cur.bits = (cur.bits & ~clr_mask) | set_mask;
        if (cur.irq_en && (cur.bits & clr_mask) != '0) begin
            next_cur.irq = 1'b1;
        end else if (wr_acc && i_paddr == ADDR_STATUS && i_pwdata[STATUS_IRQ_BIT]) begin
            next_cur.irq = 1'b0;
        end
        if (wr_acc && i_paddr == ADDR_MODE) begin
            next_cur.mode = i_pwdata[LEVELS-1:0];
        end
        if (wr_acc && i_paddr == ADDR_CTRL) begin
            next_cur.irq_en  = i_pwdata[CTRL_IRQ_EN_BIT];
            next_cur.chassis = i_pwdata[CTRL_CHASSIS_LSB +: 2];
        end
        next_cur.phase     = cur.phase + 2'h1;
        next_cur.nib       = cur.bits[{cur.phase, 2'h0} +: NIBBLE];
        next_cur.nib_phase = cur.phase;
        // local data delayed to meet peer data through the syncs
        next_cur.nib_d = {cur.nib_d[SYNC_DEPTH-2:0], cur.nib};
        next_cur.ph_d  = {cur.ph_d[SYNC_DEPTH-1:0], cur.nib_phase};
        // two-flop capture of network pins
        next_cur.peer_s1 = i_peer_fanin;
        next_cur.peer_s2 = cur.peer_s1;
        next_cur.top_s1  = i_top_result;
        next_cur.top_s2  = cur.top_s1;
        // read data captured in the setup phase
        next_cur.rdata = '0;
        if (i_psel && !i_penable && !i_pwrite) begin
            unique case (i_paddr)
                ADDR_LOW:    next_cur.rdata[REG_BITS-1:0] = cur.bits[REG_BITS-1:0];
                ADDR_HIGH:   next_cur.rdata[REG_BITS-1:0] = cur.bits[NUM_BITS-1:REG_BITS];
                ADDR_MODE:   next_cur.rdata[LEVELS-1:0] = cur.mode;
                ADDR_CTRL: begin
                    next_cur.rdata[CTRL_IRQ_EN_BIT] = cur.irq_en;
                    next_cur.rdata[CTRL_CHASSIS_LSB +: 2] = cur.chassis;
                end
                ADDR_STATUS: begin
                    next_cur.rdata[STATUS_IRQ_BIT] = cur.irq;
                    next_cur.rdata[STATUS_PHASE_LSB +: 2] = cur.phase;
                end
                default:     next_cur.rdata = '0;
            endcase
        end
    end

    // state register; clock enable freezes everything
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cur      <= '0;
            cur.mode <= MODE_RESET;
        end else if (i_ce) begin
            cur <= next_cur;
        end
    end

    assign o_prdata       = cur.rdata;
    assign o_fanin_nibble = cur.nib;
    assign o_fanin_phase  = cur.nib_phase;
    assign o_barrier_irq  = cur.irq;

    // each unit's level-one inputs are this node plus three peers
    fan_tree_unit u_fan_unit_even (
        .i_clk         (i_clk),
        .i_rst         (i_rst),
        .i_ce          (i_ce),
        .i_route       (ROUTE_EVEN),
        .i_nibble      (cur.nib_d[SYNC_DEPTH-1]),
        .i_shortcut    (shortcut),
        .i_peer        ({cur.peer_s2[4][1:0], cur.peer_s2[3][1:0], cur.peer_s2[2][1:0],
                         cur.peer_s2[1][1:0], cur.peer_s2[0][1:0]}),
        .i_top_result  (cur.top_s2[1:0]),
        .o_up          (o_tree_up[1:0]),
        .o_peer_fanout ({o_peer_fanout[4][1:0], o_peer_fanout[3][1:0],
                         o_peer_fanout[2][1:0], o_peer_fanout[1][1:0],
                         o_peer_fanout[0][1:0]}),
        .o_local_done  (done[1:0])
    );

    fan_tree_unit u_fan_unit_odd (
        .i_clk         (i_clk),
        .i_rst         (i_rst),
        .i_ce          (i_ce),
        .i_route       (ROUTE_ODD),
        .i_nibble      (cur.nib_d[SYNC_DEPTH-1]),
        .i_shortcut    (shortcut),
        .i_peer        ({cur.peer_s2[4][3:2], cur.peer_s2[3][3:2], cur.peer_s2[2][3:2],
                         cur.peer_s2[1][3:2], cur.peer_s2[0][3:2]}),
        .i_top_result  (cur.top_s2[3:2]),
        .o_up          (o_tree_up[3:2]),
        .o_peer_fanout ({o_peer_fanout[4][3:2], o_peer_fanout[3][3:2],
                         o_peer_fanout[2][3:2], o_peer_fanout[1][3:2],
                         o_peer_fanout[0][3:2]}),
        .o_local_done  (done[3:2])
    );

    // final AND and broadcast across modules
    system_combine_unit u_system_combine_unit (
        .i_clk       (i_clk),
        .i_rst       (i_rst),
        .i_ce        (i_ce),
        .i_mode      (chassis_mode_t'(cur.chassis)),
        .i_pe        (i_sys_pe),
        .i_io        (i_sys_io),
        .i_red       (i_sys_red),
        .i_peer      (i_sys_peer),
        .i_edge      (i_sys_edge),
        .o_peer_out  (o_sys_peer),
        .o_edge_out  (o_sys_edge),
        .o_broadcast (o_sys_broadcast)
    );

    // checks next to the register unit
    a_set_on_write : assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce && wr_acc && i_paddr == ADDR_LOW |=> (cur.bits[REG_BITS-1:0] & $past(i_pwdata[REG_BITS-1:0])) == $past(i_pwdata[REG_BITS-1:0]))
        else $error("arrival write did not set bit");
    a_hold_bits : assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce && done == '0 |=> (cur.bits & $past(cur.bits)) == $past(cur.bits))
        else $error("barrier bit dropped without completion");
    a_clear_done : assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce && set_mask == '0 && clr_mask != '0 |=> (cur.bits & $past(clr_mask)) == '0)
        else $error("completion did not clear bit");
    a_irq_raise : assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce && cur.irq_en && (cur.bits & clr_mask) != '0 |=> o_barrier_irq)
        else $error("interrupt not raised on completion");
    a_no_irq_off : assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce && !cur.irq_en && !cur.irq |=> !o_barrier_irq)
        else $error("interrupt raised while disabled");
    a_four_phases : assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce ##1 i_ce |=> o_fanin_phase == 2'($past(o_fanin_phase) + 2'h1))
        else $error("transfer phase did not advance");
    a_fanout_copy : assert property (@(posedge i_clk) disable iff (i_rst)
        o_peer_fanout[0][0] == '0 || o_peer_fanout[0][0] == '1)
        else $error("fan-out copies differ");
    c_arrival : cover property (@(posedge i_clk) wr_acc && i_paddr == ADDR_LOW);
    c_complete : cover property (@(posedge i_clk) (cur.bits & clr_mask) != '0);
    c_irq : cover property (@(posedge i_clk) cur.irq_en ##1 o_barrier_irq);
endmodule // barrier_sync_node
`default_nettype wire

// ==== hw/barrier_sync_pkg.sv ====
// barrier_sync_pkg: shared constants, register map and mode type of the
// barrier synchronisation node. Assumes a 32-bit APB host and lock-step peers.
package barrier_sync_pkg;
    // barrier bits, transfers and tree shape
    localparam int NUM_BITS   = 16;
    localparam int REG_BITS   = 8;
    localparam int NIBBLE     = 4;
    localparam int PHASES     = 4;
    localparam int LEVELS     = 5;
    localparam int PEERS      = 3;
    localparam int UNIT_CHANS = 2;
    localparam int SYNC_DEPTH = 2;
    // register byte offsets
    localparam logic [11:0] ADDR_LOW    = 12'h000;
    localparam logic [11:0] ADDR_HIGH   = 12'h004;
    localparam logic [11:0] ADDR_MODE   = 12'h008;
    localparam logic [11:0] ADDR_CTRL   = 12'h00C;
    localparam logic [11:0] ADDR_STATUS = 12'h010;
    // field positions and reset values
    localparam int CTRL_IRQ_EN_BIT  = 0;
    localparam int CTRL_CHASSIS_LSB = 2;
    localparam int STATUS_IRQ_BIT   = 0;
    localparam int STATUS_PHASE_LSB = 4;
    localparam logic [LEVELS-1:0] MODE_RESET = 5'h1F;
    // board route straps of the two fan units
    localparam logic ROUTE_EVEN = 1'b0;
    localparam logic ROUTE_ODD  = 1'b1;
    // chassis arrangement of the combine unit
    typedef enum logic [1:0] {CH_SINGLE, CH_TWO, CH_FOUR_EDGE, CH_FOUR_CENTER} chassis_mode_t;
endpackage

// ==== hw/fan_tree_unit.sv ====
// fan_tree_unit: five-level 4-to-1 AND fan-in and 1-to-4 fan-out for two
// barrier channels. Assumes peer inputs already synchronised to i_clk.
`timescale 1ns/1ps
`default_nettype none
module fan_tree_unit
    import barrier_sync_pkg::*;
(
    // clock, reset, enable
    input  wire logic                                   i_clk,
    input  wire logic                                   i_rst,
    input  wire logic                                   i_ce,
    // strap and controls
    input  wire logic                                   i_route,
    input  wire logic [NIBBLE-1:0]                      i_nibble,
    input  wire logic [LEVELS-1:0]                      i_shortcut,
    // network side
    input  wire logic [LEVELS-1:0][UNIT_CHANS-1:0][PEERS-1:0] i_peer,
    input  wire logic [UNIT_CHANS-1:0]                  i_top_result,
    output logic      [UNIT_CHANS-1:0]                  o_up,
    output logic      [LEVELS-1:0][UNIT_CHANS-1:0][PEERS-1:0] o_peer_fanout,
    // toward the register unit
    output logic      [UNIT_CHANS-1:0]                  o_local_done
);
    typedef struct packed {
        logic [UNIT_CHANS-1:0]             up;
        logic [LEVELS-1:0][UNIT_CHANS-1:0] fan;
        logic [UNIT_CHANS-1:0]             done;
    } fan_state_t;

    fan_state_t                        cur;
    fan_state_t                        next_cur;
    logic [LEVELS-1:0][UNIT_CHANS-1:0] and_out;
    logic [LEVELS:0][UNIT_CHANS-1:0]   below;
    logic [LEVELS:0][UNIT_CHANS-1:0]   down;

    // per channel tree; a closed bypass point sends a neutral 1 upward
    for (genvar c = 0; c < UNIT_CHANS; c++) begin : g_chan
        assign below[0][c] = i_route ? i_nibble[c + 2] : i_nibble[c];
        assign down[LEVELS][c] = i_top_result[c];
        for (genvar l = 0; l < LEVELS; l++) begin : g_lvl
            assign and_out[l][c] = below[l][c] & (&i_peer[l][c]);
            assign below[l + 1][c] = i_shortcut[l] ? 1'b1 : and_out[l][c];
            assign down[l][c] = i_shortcut[l] ? and_out[l][c] : down[l + 1][c];
        end
    end

    // registered outputs
    always_comb begin
        next_cur      = cur;
        next_cur.up   = below[LEVELS];
        next_cur.fan  = down[LEVELS-1:0];
        // result walks back down the same path
        next_cur.done = down[0];
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cur <= '0;
        end else if (i_ce) begin
            cur <= next_cur;
        end
    end

    assign o_up         = cur.up;
    assign o_local_done = cur.done;
    // each result copied to every peer
    for (genvar l = 0; l < LEVELS; l++) begin : g_rep
        for (genvar c = 0; c < UNIT_CHANS; c++) begin : g_rc
            assign o_peer_fanout[l][c] = {PEERS{cur.fan[l][c]}};
        end
    end

    a_fanin_and : assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce && i_shortcut == '0 |=> o_up == $past(and_out[LEVELS-1]))
        else $error("fan-in AND result wrong");
    a_bypass_route : assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce && i_shortcut[0] |=> o_local_done == $past(and_out[0]) &&
        (!$past(i_shortcut[LEVELS-1]) || o_up == '1))
        else $error("bypass did not return AND output");
endmodule // fan_tree_unit
`default_nettype wire

// ==== hw/system_combine_unit.sv ====
// system_combine_unit: final AND across modules and chassis, with broadcast.
// Assumes the five module and chassis inputs come from other boards and are synchronised here.
`timescale 1ns/1ps
`default_nettype none
module system_combine_unit
    import barrier_sync_pkg::*;
(
    // clock, reset, enable
    input  wire logic              i_clk,
    input  wire logic              i_rst,
    input  wire logic              i_ce,
    input  wire chassis_mode_t     i_mode,
    // module and chassis inputs
    input  wire logic [NIBBLE-1:0] i_pe,
    input  wire logic [NIBBLE-1:0] i_io,
    input  wire logic [NIBBLE-1:0] i_red,
    input  wire logic [NIBBLE-1:0] i_peer,
    input  wire logic [NIBBLE-1:0] i_edge,
    // outputs
    output logic      [NIBBLE-1:0] o_peer_out,
    output logic      [NIBBLE-1:0] o_edge_out,
    output logic      [NIBBLE-1:0] o_broadcast
);
    typedef struct packed {
        logic [4:0][NIBBLE-1:0] s1;
        logic [4:0][NIBBLE-1:0] s2;
        logic [NIBBLE-1:0]      peer_out;
        logic [NIBBLE-1:0]      edge_out;
        logic [NIBBLE-1:0]      bcast;
    } comb_state_t;

    comb_state_t       cur;
    comb_state_t       next_cur;
    logic [NIBBLE-1:0] and_io;
    logic [NIBBLE-1:0] and_chassis;
    logic [NIBBLE-1:0] and_pair;

    assign and_io      = cur.s2[1] & cur.s2[2];
    assign and_chassis = and_io & cur.s2[0];
    assign and_pair    = and_chassis & cur.s2[4];

    // two-flop sync of board inputs, then arrangement selection
    always_comb begin
        next_cur          = cur;
        next_cur.s1       = {i_edge, i_peer, i_red, i_io, i_pe};
        next_cur.s2       = cur.s1;
        next_cur.peer_out = and_chassis;
        next_cur.edge_out = '0;
        unique case (i_mode)
            CH_SINGLE:      next_cur.bcast = and_chassis;
            CH_TWO:         next_cur.bcast = and_chassis & cur.s2[3];
            CH_FOUR_EDGE:   next_cur.bcast = cur.s2[3];
            CH_FOUR_CENTER: begin
                next_cur.peer_out = and_pair;
                next_cur.edge_out = and_pair & cur.s2[3];
                next_cur.bcast    = and_pair & cur.s2[3];
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cur <= '0;
        end else if (i_ce) begin
            cur <= next_cur;
        end
    end

    assign o_peer_out  = cur.peer_out;
    assign o_edge_out  = cur.edge_out;
    assign o_broadcast = cur.bcast;

    a_two_chassis : assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce && i_mode == CH_TWO |=> o_broadcast == ($past(and_chassis) & $past(cur.s2[3])))
        else $error("two-chassis final AND wrong");
    a_combine_order : assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce |=> o_peer_out == '0 || $past(and_io) != '0)
        else $error("chassis AND not built on I/O AND");
    c_four_center : cover property (@(posedge i_clk) i_mode == CH_FOUR_CENTER && o_edge_out != '0);
endmodule // system_combine_unit
`default_nettype wire

// ==== sim/peer_model.sv ====
// peer_model: far side of the fan and combine pins of one node.
// Assumes lock-step peers that all report arrival together on command.
`timescale 1ns/1ps
`default_nettype none
module peer_model
    import barrier_sync_pkg::*;
(
    // command from the bench
    input  wire logic                                   i_arrive,
    // toward the node
    output logic      [LEVELS-1:0][NIBBLE-1:0][PEERS-1:0] o_peer_fanin,
    output logic      [NIBBLE-1:0]                      o_top_result,
    output logic      [NIBBLE-1:0]                      o_sys
);
    // peers show 1 only once all have arrived
    assign o_peer_fanin = {(LEVELS*NIBBLE*PEERS){i_arrive}};
    assign o_top_result = {NIBBLE{i_arrive}};
    assign o_sys        = {NIBBLE{i_arrive}};
endmodule // peer_model
`default_nettype wire

// ==== sim/testbench.sv ====
// testbench: drives APB reads and writes, notes expected read data in a queue.
// Assumes zero-wait APB and peers that answer only when told to arrive.
`timescale 1ns/1ps
`default_nettype none
module testbench
    import barrier_sync_pkg::*;
;
    logic i_clk, i_rst, i_ce, i_psel, i_penable, i_pwrite, arrive, o_pready, o_pslverr;
    logic o_barrier_irq;
    logic [11:0] i_paddr;
    logic [31:0] i_pwdata, o_prdata, rv;
    logic [32:0] e;
    logic [LEVELS-1:0][NIBBLE-1:0][PEERS-1:0] i_peer_fanin, o_peer_fanout;
    logic [NIBBLE-1:0] i_top_result, o_tree_up, o_fanin_nibble, sys;
    logic [NIBBLE-1:0] o_sys_peer, o_sys_edge, o_sys_broadcast;
    logic [1:0] o_fanin_phase;
    logic [32:0] expq[$];
    int fail_count = 0;
    int samples_checked = 0;
    int n;
    barrier_sync_node dut (.i_clk, .i_rst, .i_ce, .i_psel, .i_penable, .i_pwrite, .i_paddr,
        .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_peer_fanin, .i_top_result, .o_tree_up,
        .o_peer_fanout, .o_fanin_nibble, .o_fanin_phase, .i_sys_pe(sys), .i_sys_io(sys),
        .i_sys_red(sys), .i_sys_peer(sys), .i_sys_edge(sys), .o_sys_peer, .o_sys_edge,
        .o_sys_broadcast, .o_barrier_irq);
    peer_model far (.i_arrive(arrive), .o_peer_fanin(i_peer_fanin),
        .o_top_result(i_top_result), .o_sys(sys));
    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'b1;
        do @(posedge i_clk); while (o_pready !== 1'b1);
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [32:0] x);
        expq.push_back(x);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic give_verdict();
        if (fail_count == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // watcher: takes the oldest note when a read completes
    always @(posedge i_clk) begin
        if (i_psel && i_penable && !i_pwrite && o_pready === 1'b1 && expq.size() > 0) begin
            e = expq.pop_front();
            samples_checked++;
            if ({o_pslverr, o_prdata} !== e) begin
                fail_count++;
                $display("unexpected read %h: expected %h seen %h", i_paddr, e,
                         {o_pslverr, o_prdata});
            end
        end
    end
    // 200 MHz clock
    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end
    // watchdog: the whole run needs well under a thousand cycles
    initial begin
        #20000;
        fail_count++;
        give_verdict();
    end
    initial begin
        {i_rst, i_ce, i_psel, i_penable, i_pwrite, arrive} = 6'b110000;
        i_paddr = 12'h000;
        i_pwdata = 32'h0;
        rv = $urandom(32'hF4E7D6A7);
        repeat (3) @(posedge i_clk);
        i_rst <= 1'b0;
        rd(ADDR_MODE, {28'h0, MODE_RESET});
        rd(ADDR_LOW, 33'h0);
        apb(1'b1, ADDR_MODE, 32'h0000001E);
        apb(1'b1, ADDR_CTRL, 32'h00000005);
        apb(1'b1, ADDR_LOW, 32'h00000001);
        apb(1'b1, ADDR_HIGH, {24'h0, rv[7:0]});
        apb(1'b1, ADDR_HIGH, 32'h0);
        // peers silent: bits must hold through several full phase rounds
        repeat (20) @(posedge i_clk);
        rd(ADDR_LOW, 33'h1);
        rd(ADDR_HIGH, {25'h0, rv[7:0]});
        arrive <= 1'b1;
        n = 0;
        while (o_barrier_irq !== 1'b1 && n < 100) begin
            @(posedge i_clk);
            n++;
        end
        samples_checked++;
        if (n == 100) begin
            fail_count++;
            $display("unexpected irq: expected 1 seen %b", o_barrier_irq);
        end
        // let every phase of the round and the combine syncs settle
        repeat (8) @(posedge i_clk);
        samples_checked++;
        if ({o_tree_up, o_sys_peer, o_sys_edge, o_sys_broadcast} !== 16'hFF0F) begin
            fail_count++;
            $display("unexpected tree/sys: expected FF0F seen %h",
                     {o_tree_up, o_sys_peer, o_sys_edge, o_sys_broadcast});
        end
        rd(ADDR_LOW, 33'h0);
        rd(ADDR_HIGH, 33'h0);
        rd(12'h014, {1'b1, 32'h0});
        give_verdict();
    end
endmodule // testbench
`default_nettype wire
